// ### sxic_ctrl.sv
/*
 * Six-level interrupt controller: pin capture, two-stage request flags,
 * mask, priority and the register-file port for the three control registers.
 * Assumes the core drives reg strobes and sequencer pulses on clk_i and
 * services the winner reported on int_pending_o / int_level_o.
 */
//
// Contract
// (R1) Six levels, each maskable and prioritised
// (R2) Mask bit 7 is master enable
// (R3) Mask FB, request FA, priority F9
// (R4) Level n vectors at 2n; fixed sources
// (R5) Levels 0,1,2 from port3 pins 2,3,1
// (R6) Pin edge captured, synchronised, delayed
// (R7) Level 3 pin only when receive off
// (R8) Internal and external sources ORed
// (R9) Request edge held until sampling point
// (R10) Sample in cycle before opcode fetch
// (R11) Sample to flags; ack clears winner
// (R12) Register access reaches flags directly
// (R13) All interrupts disabled after reset
// (R14) Software sets priority, mask, request
// (R15) Write-only priority picks the winner
// (R16) Pair selectors on bits 5,2,1
// (R17) Bits 4,3,0 encode group order
// (R18) Priority bits 7,6 have no effect
// (R19) Level enables; master auto off/on
// (R20) Request clear, read-only until unmask
// (R21) Unused group codes give fixed order
//
`default_nettype none

`include "sxic_regs.svh"

module sxic_ctrl
	import sxic_pkg::*;
#(
	parameter int LEVELS = 6
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          reset_i,
	// Register-file port
	input  wire logic [7:0]    reg_addr_i,
	input  wire logic          reg_wr_i,
	input  wire logic          reg_rd_i,
	input  wire logic [7:0]    reg_wdata_i,
	output logic      [7:0]    reg_rdata_o,
	// Core sequencer
	input  wire sxic_core_op_t core_op_i,
	// Port 3 pins
	input  wire logic          port3_bit_zero_i,
	input  wire logic          port3_bit_one_i,
	input  wire logic          port3_bit_two_i,
	input  wire logic          port3_bit_three_i,
	// On-chip sources
	input  wire sxic_periph_t  periph_i,
	// Service request to the core
	output logic               int_pending_o,
	output logic      [2:0]    int_level_o,
	output logic      [7:0]    vector_addr_o
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [3:0]        ext_fall;
	logic [LEVELS-1:0] req_pulse;
	logic [LEVELS-1:0] stage1_reg;
	logic [LEVELS-1:0] stage1_next;
	logic [LEVELS-1:0] flags_reg;
	logic [LEVELS-1:0] flags_next;
	logic [7:0]        mask_reg;
	logic [7:0]        mask_next;
	logic [5:0]        prio_reg;
	logic              armed_reg;
	logic [LEVELS-1:0] enabled;
	logic [LEVELS-1:0] win_onehot;
	logic              win_valid;
	logic [2:0]        win_level;
	logic              wr_mask;
	logic              wr_req;
	logic              wr_prio;

	assign wr_mask = reg_wr_i && (reg_addr_i == `SXIC_ADDR_MASK); // [R3]
	assign wr_req  = reg_wr_i && (reg_addr_i == `SXIC_ADDR_REQ);  // [R3]
	assign wr_prio = reg_wr_i && (reg_addr_i == `SXIC_ADDR_PRIO); // [R3]

	////////////////////////////////////////////////////////////////////////
	// Pin capture

	// Lane order: pins zero, one, two, three of port 3
	sxic_edge_sync #(
		.WIDTH (4)
	) u_edge_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.pins_i  ({port3_bit_three_i, port3_bit_two_i,
			port3_bit_one_i, port3_bit_zero_i}),
		.fall_o  (ext_fall)
	); // [R6]

	////////////////////////////////////////////////////////////////////////
	// Request sources

	always_comb begin
		req_pulse    = '0;
		req_pulse[0] = ext_fall[2] | periph_i.handshake_data_valid[0]; // [R5] [R8]
		req_pulse[1] = ext_fall[3] | periph_i.handshake_data_valid[1]; // [R5] [R8]
		// Pin one doubles as the counter input pin
		req_pulse[2] = ext_fall[1] | periph_i.handshake_data_valid[2]; // [R4] [R5] [R8]
		// Receive enabled takes the pin away from level three
		req_pulse[3] = periph_i.serial_rx_enable ?
			periph_i.serial_rx_event : ext_fall[0]; // [R7]
		req_pulse[4] = periph_i.counter_zero_eoc | periph_i.serial_tx_event; // [R4] [R8]
		req_pulse[5] = periph_i.counter_one_eoc; // [R4]
	end

	////////////////////////////////////////////////////////////////////////
	// First-stage latches

	// A pulse in the sample cycle stays behind for the next sample
	always_comb begin
		stage1_next = core_op_i.sample ? '0 : stage1_reg; // [R10]
		stage1_next = stage1_next | req_pulse; // [R9]
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			stage1_reg <= '0;
		end else begin
			stage1_reg <= stage1_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Second-stage flags (request register)

	// Order matters: write, then ack clear, then sample set, so sets win
	always_comb begin
		flags_next = flags_reg;
		if (wr_req && armed_reg) begin
			flags_next = reg_wdata_i[LEVELS-1:0]; // [R12] [R20]
		end
		if (core_op_i.ack && win_valid) begin
			flags_next = flags_next & ~win_onehot; // [R11]
		end
		if (core_op_i.sample) begin
			flags_next = flags_next | stage1_reg; // [R10] [R11]
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			flags_reg <= `SXIC_REQ_RESET; // [R20]
		end else begin
			flags_reg <= flags_next;
		end
	end

	// Writes to the request register are ignored until the first unmask
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			armed_reg <= 1'b0; // [R20]
		end else if (core_op_i.unmask) begin
			armed_reg <= 1'b1; // [R20]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mask register

	// Bit 6 is reserved and held at zero
	always_comb begin
		mask_next = mask_reg;
		if (wr_mask) begin
			mask_next = reg_wdata_i & `SXIC_MASK_WRITABLE; // [R19]
		end
		if (core_op_i.mask_off || core_op_i.ack) begin
			mask_next[`SXIC_MASK_MASTER] = 1'b0; // [R2] [R19]
		end
		if (core_op_i.unmask || core_op_i.ret) begin
			mask_next[`SXIC_MASK_MASTER] = 1'b1; // [R2] [R19]
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mask_reg <= `SXIC_MASK_RESET; // [R13]
		end else begin
			mask_reg <= mask_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Priority register

	// Top two bits are dropped on write
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			prio_reg <= `SXIC_PRIO_RESET;
		end else if (wr_prio) begin
			prio_reg <= reg_wdata_i[5:0]; // [R15] [R18]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Enable gating and resolution

	assign enabled = flags_reg & mask_reg[`SXIC_MASK_LEVELS]
		& {LEVELS{mask_reg[`SXIC_MASK_MASTER]}}; // [R1] [R2] [R19]

	sxic_prio u_prio (
		.req_i   (enabled),
		.prio_i  (prio_reg),
		.valid_o (win_valid),
		.level_o (win_level)
	); // [R15]

	always_comb begin
		win_onehot = '0;
		win_onehot[win_level] = win_valid;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs to the core

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			int_pending_o <= 1'b0;
			int_level_o   <= 3'h0;
			vector_addr_o <= 8'h00;
		end else begin
			int_pending_o <= win_valid;
			int_level_o   <= win_level;
			vector_addr_o <= {4'h0, win_level, 1'b0}; // [R4]
		end
	end

	// Priority register reads as zero: it is write-only
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= `SXIC_READ_ZERO;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`SXIC_ADDR_MASK: reg_rdata_o <= mask_reg;
				`SXIC_ADDR_REQ:  reg_rdata_o <= {2'b00, flags_reg}; // [R12]
				`SXIC_ADDR_PRIO: reg_rdata_o <= `SXIC_READ_ZERO; // [R15]
				default:         reg_rdata_o <= `SXIC_READ_ZERO;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// Pending is registered, so it may stand one cycle after the mask-off
	chk_master_off_op: assert property ( // [R2]
		core_op_i.mask_off && !core_op_i.unmask && !core_op_i.ret
		|=> !mask_reg[`SXIC_MASK_MASTER] ##1 !int_pending_o
	) else $error("master enable still set after mask-off op");

	chk_master_on_op: assert property ( // [R2]
		core_op_i.unmask |=> mask_reg[`SXIC_MASK_MASTER] && armed_reg
	) else $error("unmask op did not set master enable");

	chk_ack_master_off: assert property ( // [R19]
		core_op_i.ack && !core_op_i.unmask && !core_op_i.ret
		|=> !mask_reg[`SXIC_MASK_MASTER]
	) else $error("interrupt cycle left master enable set");

	chk_gate_blocks_all: assert property ( // [R2]
		!mask_reg[`SXIC_MASK_MASTER] |=> !int_pending_o
	) else $error("pending raised with master enable off");

	chk_pin_delay_two: assert property ( // [R6]
		$fell(port3_bit_two_i) |-> ##3 (ext_fall[2] && req_pulse[0])
	) else $error("pin edge did not reach level zero after three cycles");

	chk_rx_gate_pin: assert property ( // [R7]
		periph_i.serial_rx_enable && !periph_i.serial_rx_event
		|-> !req_pulse[3]
	) else $error("pin request reached level three while receive enabled");

	chk_stage1_holds: assert property ( // [R9]
		(req_pulse != '0) ##1 !core_op_i.sample
		|-> ((stage1_reg & $past(req_pulse)) == $past(req_pulse))
	) else $error("first-stage latch lost a request before sampling");

	chk_sample_moves: assert property ( // [R11]
		core_op_i.sample
		|=> ((flags_reg & $past(stage1_reg)) == $past(stage1_reg))
			&& ((stage1_reg & ~$past(req_pulse)) == '0)
	) else $error("sampling did not move latches into flags");

	chk_ack_clears_win: assert property ( // [R11]
		core_op_i.ack && win_valid && !core_op_i.sample && !wr_req
		|=> flags_reg == ($past(flags_reg) & ~$past(win_onehot))
	) else $error("interrupt cycle did not clear just the winning flag");

	chk_req_readonly: assert property ( // [R20]
		!armed_reg && !core_op_i.sample && !core_op_i.ack
		|=> flags_reg == $past(flags_reg)
	) else $error("request flags changed before first unmask");

	chk_pending_flag: assert property ( // [R1]
		$rose(int_pending_o) |-> $past(flags_reg[win_level]
			&& mask_reg[win_level])
	) else $error("pending level not flagged and enabled");

	chk_ret_sets_master: assert property ( // [R19]
		core_op_i.ret |=> mask_reg[`SXIC_MASK_MASTER]
	) else $error("return op did not set master enable");

	chk_ack_pending_drop: assert property ( // [R2]
		core_op_i.ack && !core_op_i.unmask && !core_op_i.ret |-> ##2 !int_pending_o
	) else $error("pending still raised two cycles after interrupt cycle");

	chk_mask_write_lands: assert property ( // [R19]
		wr_mask && !core_op_i.mask_off && !core_op_i.ack && !core_op_i.unmask
			&& !core_op_i.ret
		|=> mask_reg == ($past(reg_wdata_i) & `SXIC_MASK_WRITABLE)
	) else $error("mask write did not land");

	chk_stage1_until_sample: assert property ( // [R9]
		!core_op_i.sample
		|=> ((stage1_reg & $past(stage1_reg)) == $past(stage1_reg))
	) else $error("first-stage latch dropped before sampling point");

	chk_flag_set_sample: assert property ( // [R10]
		!core_op_i.sample && !wr_req
		|=> ((flags_reg & ~$past(flags_reg)) == '0)
	) else $error("request flag set outside a sampling point");

	chk_req_write_direct: assert property ( // [R12]
		wr_req && armed_reg && !core_op_i.ack && !core_op_i.sample
		|=> flags_reg == $past(reg_wdata_i[LEVELS-1:0])
	) else $error("request register write did not reach the flags");

	chk_winner_enabled: assert property ( // [R15]
		(win_valid == (enabled != '0)) && (!win_valid || enabled[win_level])
	) else $error("winner is not an enabled pending level");

endmodule

`default_nettype wire

// ### sxic_regs.svh
/*
 * Register addresses, field positions, reset values and level numbers of the
 * six-level interrupt controller.
 * Assumes it is included by bare name from module and bench files.
 */
`ifndef SXIC_REGS_SVH
`define SXIC_REGS_SVH

// Register-file addresses
`define SXIC_ADDR_PRIO       8'hF9
`define SXIC_ADDR_REQ        8'hFA
`define SXIC_ADDR_MASK       8'hFB

// Mask register fields
`define SXIC_MASK_MASTER     7
`define SXIC_MASK_LEVELS     5:0
`define SXIC_MASK_RESET      8'h00
// Writable mask bits: bit 6 is reserved and always reads zero
`define SXIC_MASK_WRITABLE   8'hBF

// Request register fields
`define SXIC_REQ_RESET       6'h00
`define SXIC_READ_ZERO       8'h00

// Priority register fields: pair selectors and group-order code bits
`define SXIC_PRIO_RESET      6'h00
`define SXIC_PRIO_SEL_A      5
`define SXIC_PRIO_SEL_B      2
`define SXIC_PRIO_SEL_C      1
`define SXIC_PRIO_GRP_HI     4
`define SXIC_PRIO_GRP_MID    3
`define SXIC_PRIO_GRP_LO     0

// Level numbers of each pair, preferred member first when selector is clear
`define SXIC_LVL_A_FIRST     3'h5
`define SXIC_LVL_A_SECOND    3'h3
`define SXIC_LVL_B_FIRST     3'h2
`define SXIC_LVL_B_SECOND    3'h0
`define SXIC_LVL_C_FIRST     3'h1
`define SXIC_LVL_C_SECOND    3'h4

// Group-order codes from bits 4, 3, 0
`define SXIC_ORD_CAB         3'h1
`define SXIC_ORD_ABC         3'h2
`define SXIC_ORD_ACB         3'h3
`define SXIC_ORD_BCA         3'h4
`define SXIC_ORD_CBA         3'h5
`define SXIC_ORD_BAC         3'h6

// Pin-path delay from a falling pin to the edge pulse, in clock cycles
`define SXIC_PIN_DELAY       3

`endif

// ### sxic_pkg.sv
/*
 * Types shared by the interrupt controller modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package sxic_pkg;

	// Core sequencer strobes, each a one-cycle pulse
	typedef struct packed {
		logic unmask;      // global_unmask_op
		logic mask_off;    // global_mask_off_op
		logic ret;         // return_from_service_op
		logic sample;      // last cycle before opcode fetch
		logic ack;         // interrupt cycle taken
	} sxic_core_op_t;

	// On-chip request sources, each a one-cycle pulse except the enable
	typedef struct packed {
		logic       serial_rx_enable;
		logic       serial_rx_event;
		logic       serial_tx_event;
		logic       counter_zero_eoc;
		logic       counter_one_eoc;
		logic [2:0] handshake_data_valid;
	} sxic_periph_t;

	typedef enum logic [1:0] {
		GRP_A,
		GRP_B,
		GRP_C
	} sxic_group_t;

endpackage

`default_nettype wire

// ### sxic_edge_sync.sv
/*
 * Pin synchroniser and falling-edge detector, one lane per pin.
 * Assumes raw asynchronous pins; outputs are one-cycle pulses on clk_i.
 */
`default_nettype none

module sxic_edge_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	// Pins and pulses
	input  wire logic [WIDTH-1:0] pins_i,
	output logic      [WIDTH-1:0] fall_o
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] prev_reg;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_lane
			// Idle pins sit high, so reset to high avoids a false edge
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					meta_reg[g] <= 1'b1;
					sync_reg[g] <= 1'b1;
					prev_reg[g] <= 1'b1;
					fall_o[g]   <= 1'b0;
				end else begin
					meta_reg[g] <= pins_i[g];
					sync_reg[g] <= meta_reg[g];
					prev_reg[g] <= sync_reg[g];
					fall_o[g]   <= prev_reg[g] & ~sync_reg[g];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ### sxic_prio.sv
/*
 * Combinational priority resolver over the six enabled request flags.
 * Assumes req_i already gated by the per-level and master enables.
 */
`default_nettype none

`include "sxic_regs.svh"

module sxic_prio
	import sxic_pkg::*;
(
	// Requests and priority setting
	input  wire logic [5:0] req_i,
	input  wire logic [5:0] prio_i,
	// Winner
	output logic            valid_o,
	output logic [2:0]      level_o
);

	// Returns {valid, level} for one pair; swap reverses the order
	function automatic logic [3:0] pair_pick(input logic [5:0] r,
		input logic [2:0] first, input logic [2:0] second, input logic swap);
		logic [2:0] hi;
		logic [2:0] lo;
		hi = swap ? second : first;
		lo = swap ? first : second;
		if (r[hi]) begin
			pair_pick = {1'b1, hi};
		end else if (r[lo]) begin
			pair_pick = {1'b1, lo};
		end else begin
			pair_pick = 4'h0;
		end
	endfunction

	logic [3:0]  grp_pick [3];
	sxic_group_t ord [3];

	always_comb begin
		grp_pick[GRP_A] = pair_pick(req_i, `SXIC_LVL_A_FIRST, `SXIC_LVL_A_SECOND,
			prio_i[`SXIC_PRIO_SEL_A]); // [R16]
		grp_pick[GRP_B] = pair_pick(req_i, `SXIC_LVL_B_FIRST, `SXIC_LVL_B_SECOND,
			prio_i[`SXIC_PRIO_SEL_B]); // [R16]
		grp_pick[GRP_C] = pair_pick(req_i, `SXIC_LVL_C_FIRST, `SXIC_LVL_C_SECOND,
			prio_i[`SXIC_PRIO_SEL_C]); // [R16]
	end

	always_comb begin
		case ({prio_i[`SXIC_PRIO_GRP_HI], prio_i[`SXIC_PRIO_GRP_MID],
			prio_i[`SXIC_PRIO_GRP_LO]}) // [R17]
			`SXIC_ORD_CAB: ord = '{GRP_C, GRP_A, GRP_B};
			`SXIC_ORD_ABC: ord = '{GRP_A, GRP_B, GRP_C};
			`SXIC_ORD_ACB: ord = '{GRP_A, GRP_C, GRP_B};
			`SXIC_ORD_BCA: ord = '{GRP_B, GRP_C, GRP_A};
			`SXIC_ORD_CBA: ord = '{GRP_C, GRP_B, GRP_A};
			`SXIC_ORD_BAC: ord = '{GRP_B, GRP_A, GRP_C};
			// Unused codes fall back to a fixed A, B, C order
			default:       ord = '{GRP_A, GRP_B, GRP_C}; // [R21]
		endcase
	end

	// First group in order with a pending member wins
	always_comb begin
		valid_o = 1'b0;
		level_o = 3'h0;
		for (int i = 0; i < 3; i++) begin
			if (!valid_o && grp_pick[ord[i]][3]) begin // [R15]
				valid_o = 1'b1;
				level_o = grp_pick[ord[i]][2:0];
			end
		end
	end

endmodule

`default_nettype wire

// ### sxic_core_model.sv
/* Core sequencer model: pre-fetch sample pulse, optional interrupt servicing.
 * Assumes the controller's outputs are registered on clk_i. */
`default_nettype none

module sxic_core_model
	import sxic_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// Bench controls
	input  wire logic       unmask_i,
	input  wire logic       mask_off_i,
	input  wire logic       serve_i,
	input  wire logic       slow_i,
	// Controller side
	input  wire logic       int_pending_i,
	input  wire logic [2:0] int_level_i,
	output var sxic_core_op_t core_op_o,
	output logic            taken_o,
	output logic [2:0]      taken_level_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] fetch_reg;
	logic [4:0] busy_reg;
	logic       ret_reg;

	// Last cycle of every eighth stands for the one before an opcode fetch
	assign core_op_o = '{unmask: unmask_i, mask_off: mask_off_i, ret: ret_reg,
		sample: fetch_reg == 3'h7, ack: taken_o};

	////////////////////////////////////////////////////////////////////////
	// Service routine length is short or long so both return timings occur
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fetch_reg <= 3'h0;
			busy_reg <= 5'h00;
			ret_reg <= 1'b0;
			taken_o <= 1'b0;
			taken_level_o <= 3'h0;
		end else begin
			fetch_reg <= fetch_reg + 3'h1;
			taken_o <= 1'b0;
			ret_reg <= busy_reg == 5'h03;
			if (busy_reg != 5'h00) begin
				busy_reg <= busy_reg - 5'h01;
			end else if (serve_i && int_pending_i) begin
				taken_o <= 1'b1;
				taken_level_o <= int_level_i;
				busy_reg <= slow_i ? 5'h18 : 5'h06;
			end
		end
	end
endmodule

`default_nettype wire

// ### test_sxic_ctrl.sv
/* Self-checking bench for the interrupt controller.
 * Assumes sxic_core_model stands in for the core sequencer. */
`default_nettype none
`include "sxic_regs.svh"

module test_sxic_ctrl
	import sxic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic          clk_i = 1'b0;
	logic          reset_i = 1'b1;
	logic [7:0]    addr = 8'h00;
	logic [7:0]    wdata = 8'h00;
	logic          wr = 1'b0;
	logic          rd = 1'b0;
	logic [3:0]    pins = 4'hF;
	sxic_periph_t  periph = '0;
	logic          unmask = 1'b0;
	logic          mask_off = 1'b0;
	logic          serve = 1'b0;
	logic          slow = 1'b0;
	logic [7:0]    rdata;
	logic [7:0]    vec;
	logic          pend;
	logic          taken;
	logic [2:0]    lvl;
	logic [2:0]    tlvl;
	sxic_core_op_t op;
	int            n_errors = 0;
	int            comparisons = 0;

	always #5 clk_i = ~clk_i;

	sxic_ctrl sxic_ctrl_inst (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.core_op_i(op), .port3_bit_zero_i(pins[0]), .port3_bit_one_i(pins[1]),
		.port3_bit_two_i(pins[2]), .port3_bit_three_i(pins[3]), .periph_i(periph),
		.int_pending_o(pend), .int_level_o(lvl), .vector_addr_o(vec));

	sxic_core_model sxic_core_model_inst (.clk_i(clk_i), .reset_i(reset_i),
		.unmask_i(unmask), .mask_off_i(mask_off), .serve_i(serve), .slow_i(slow),
		.int_pending_i(pend), .int_level_i(lvl), .core_op_o(op), .taken_o(taken),
		.taken_level_o(tlvl));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask

	task automatic core_cmd(input logic on);
		@(posedge clk_i);
		unmask <= on;
		mask_off <= !on;
		@(posedge clk_i);
		unmask <= 1'b0;
		mask_off <= 1'b0;
	endtask

	// Group order packed A=0 B=1 C=2, highest group in the top bits
	function automatic logic [2:0] exp_lvl(input logic [7:0] pr, input int k);
		logic [5:0] ord;
		logic [1:0] g;
		case ({pr[4], pr[3], pr[0]})
			3'h1: ord = 6'h21;
			3'h2: ord = 6'h06;
			3'h3: ord = 6'h09;
			3'h4: ord = 6'h18;
			3'h5: ord = 6'h24;
			default: ord = 6'h12;
		endcase
		g = ord[5 - 2 * (k / 2) -: 2];
		case (g)
			2'h0: return (pr[5] ^ k[0]) ? 3'h3 : 3'h5;
			2'h1: return (pr[2] ^ k[0]) ? 3'h0 : 3'h2;
			default: return (pr[1] ^ k[0]) ? 3'h4 : 3'h1;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check({7'h00, pend}, 8'h00);
		reg_rd(`SXIC_ADDR_MASK, 8'h00);
		reg_wr(`SXIC_ADDR_REQ, 8'h3F);
		reg_rd(`SXIC_ADDR_REQ, 8'h00);
		reg_rd(8'hF8, 8'h00);
	endtask

	task automatic t_init();
		reg_wr(`SXIC_ADDR_PRIO, 8'h08);
		reg_wr(`SXIC_ADDR_MASK, 8'h00);
		core_cmd(1'b1);
		reg_rd(`SXIC_ADDR_MASK, 8'h80);
		reg_wr(`SXIC_ADDR_REQ, 8'h15);
		reg_rd(`SXIC_ADDR_REQ, 8'h15);
		reg_rd(`SXIC_ADDR_PRIO, 8'h00);
		reg_wr(`SXIC_ADDR_MASK, 8'hC1);
		reg_rd(`SXIC_ADDR_MASK, 8'h81);
		wait_n(3);
		#1;
		check({5'h00, lvl}, 8'h00);
		check({7'h00, pend}, 8'h01);
		core_cmd(1'b0);
		reg_rd(`SXIC_ADDR_MASK, 8'h01);
		wait_n(2);
		#1;
		check({7'h00, pend}, 8'h00);
	endtask

	task automatic t_masks();
		reg_wr(`SXIC_ADDR_REQ, 8'h3F);
		for (int n = 0; n < 6; n++) begin
			reg_wr(`SXIC_ADDR_MASK, 8'h80 | (8'h01 << n));
			wait_n(3);
			#1;
			check({5'h00, lvl}, 8'(n));
			check(vec, 8'(2 * n));
			check({7'h00, pend}, 8'h01);
		end
		reg_wr(`SXIC_ADDR_MASK, 8'h3F);
		wait_n(3);
		#1;
		check({7'h00, pend}, 8'h00);
		reg_wr(`SXIC_ADDR_REQ, 8'h00);
	endtask

	// Only the six defined group codes are programmed
	task automatic t_order();
		logic [7:0] pr;
		int         t;
		for (int c = 1; c <= 6; c++) begin
			for (int s = 0; s < 2; s++) begin
				pr = {s[0], s[0], s[0], c[2], c[1], s[0], s[0], c[0]};
				core_cmd(1'b0);
				reg_wr(`SXIC_ADDR_PRIO, pr);
				reg_wr(`SXIC_ADDR_MASK, 8'h3F);
				reg_wr(`SXIC_ADDR_REQ, 8'h3F);
				slow <= s[0];
				serve <= 1'b1;
				core_cmd(1'b1);
				for (int k = 0; k < 6; k++) begin
					for (t = 0; t < 200 && taken !== 1'b1; t++) begin
						@(posedge clk_i);
						#1;
					end
					check({7'h00, taken}, 8'h01);
					check({5'h00, tlvl}, {5'h00, exp_lvl(pr, k)});
					check(vec, {4'h0, exp_lvl(pr, k), 1'b0});
					reg_rd(`SXIC_ADDR_MASK, 8'h3F);
				end
				@(posedge clk_i);
				serve <= 1'b0;
				wait_n(30);
				reg_rd(`SXIC_ADDR_MASK, 8'hBF);
				reg_rd(`SXIC_ADDR_REQ, 8'h00);
			end
		end
	endtask

	task automatic t_sources();
		logic [2:0] pin_lvl [4] = '{3'h3, 3'h2, 3'h0, 3'h1};
		logic [2:0] src_lvl [7] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h4, 3'h4, 3'h3};
		core_cmd(1'b0);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_i);
			periph.serial_rx_enable <= i == 4;
			pins[i % 4] <= 1'b0;
			wait_n(4);
			pins[i % 4] <= 1'b1;
			wait_n(20);
			reg_rd(`SXIC_ADDR_REQ, i == 4 ? 8'h00 : 8'h01 << pin_lvl[i % 4]);
			reg_wr(`SXIC_ADDR_REQ, 8'h00);
		end
		for (int i = 0; i < 7; i++) begin
			@(posedge clk_i);
			periph <= {1'b1, 7'h01 << i};
			@(posedge clk_i);
			periph <= 8'h80;
			wait_n(10);
			reg_rd(`SXIC_ADDR_REQ, 8'h01 << src_lvl[i]);
			reg_wr(`SXIC_ADDR_REQ, 8'h00);
		end
	endtask

	task automatic t_timing();
		@(posedge clk_i iff op.sample);
		periph.serial_tx_event <= 1'b1;
		@(posedge clk_i);
		periph.serial_tx_event <= 1'b0;
		reg_rd(`SXIC_ADDR_REQ, 8'h00);
		wait_n(8);
		reg_rd(`SXIC_ADDR_REQ, 8'h10);
		// A pulse inside the sample cycle itself waits for the next sample
		reg_wr(`SXIC_ADDR_REQ, 8'h00);
		@(posedge clk_i iff op.sample);
		wait_n(7);
		periph.serial_tx_event <= 1'b1;
		@(posedge clk_i);
		periph.serial_tx_event <= 1'b0;
		reg_rd(`SXIC_ADDR_REQ, 8'h00);
		wait_n(8);
		reg_rd(`SXIC_ADDR_REQ, 8'h10);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_init();
		t_masks();
		t_order();
		t_sources();
		t_timing();
		report_and_stop();
	end

	// About ten times the expected run length
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
endmodule

`default_nettype wire
